// ==== msf_bus_if.sv ====
`timescale 1ns/10ps
interface msf_bus_if;
  logic                 wr;
  logic [15:0]          idx;
  logic [3:0]           be;
  msf_pkg::msf_word_t   wdata;
  msf_pkg::msf_word_t   rdata;

  modport port (output wr, output idx, output be, output wdata, input rdata);
  modport core (input wr, input idx, input be, input wdata, output rdata);
endinterface : msf_bus_if

// ==== msf_harm_gate.sv ====
`timescale 1ns/10ps
module msf_harm_gate #(
  parameter int unsigned SETTLE_CYC_0 = 1,
  parameter int unsigned SETTLE_CYC_1 = 1,
  parameter int unsigned SETTLE_CYC_2 = 1,
  parameter int unsigned SETTLE_CYC_3 = 1
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Harmonic block events and setup
  input  wire logic          setup_i,
  input  wire logic          update_i,
  input  wire logic          start_now_i,
  input  wire logic [1:0]    stime_i,
  // Qualified update event
  output logic               flag_o
);

  msf_pkg::msf_harm_state_t state;
  msf_pkg::msf_harm_state_t next_state;
  logic [31:0]              cnt;
  logic [31:0]              next_cnt;

  function automatic logic [31:0] settle_cycles(input logic [1:0] sel);
    unique case (sel)
      2'd0: settle_cycles = 32'(SETTLE_CYC_0);
      2'd1: settle_cycles = 32'(SETTLE_CYC_1);
      2'd2: settle_cycles = 32'(SETTLE_CYC_2);
      2'd3: settle_cycles = 32'(SETTLE_CYC_3);
    endcase
  endfunction : settle_cycles

  // No update is flagged before the first setup of the harmonic block
  assign flag_o = update_i && (state == msf_pkg::MSF_HARM_RUN);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (setup_i) begin
      // A new setup restarts the settling wait, or goes straight to run when start_now_i is set
      if (start_now_i) begin
        next_state = msf_pkg::MSF_HARM_RUN;
      end else begin
        next_state = msf_pkg::MSF_HARM_SETTLE;
        next_cnt   = settle_cycles(stime_i);
      end
    end else begin
      unique case (state)
        msf_pkg::MSF_HARM_IDLE: begin
        end
        msf_pkg::MSF_HARM_SETTLE: begin
          if (cnt <= 32'h0000_0001) begin
            next_state = msf_pkg::MSF_HARM_RUN;
          end
          next_cnt = cnt - 32'h0000_0001;
        end
        msf_pkg::MSF_HARM_RUN: begin
        end
        default: next_state = msf_pkg::MSF_HARM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= msf_pkg::MSF_HARM_IDLE;
      cnt   <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

endmodule : msf_harm_gate

// ==== msf_pkg.sv ====
package msf_pkg;

  typedef logic [31:0] msf_word_t;

  typedef enum logic [1:0] {
    MSF_HARM_IDLE,
    MSF_HARM_SETTLE,
    MSF_HARM_RUN
  } msf_harm_state_t;

endpackage : msf_pkg

// ==== msf_regs.svh ====
`ifndef MSF_REGS_SVH
`define MSF_REGS_SVH

// Register indices; the byte address on the bus is four times the index
`define MSF_METERING_EVENT_STATUS_0_IDX     16'hE502
`define MSF_ACCUMULATION_MODE_REG_IDX     16'hF000
`define MSF_PULSE_OUTPUT_CONFIG_REG_IDX      16'hF001
`define MSF_HARMONIC_CONFIG_REG_IDX     16'hF002
`define MSF_POWER_SIGN_REG_IDX      16'hF003

// Flag positions in metering_event_status_0
`define MSF_ST_PHA_ACT      6
`define MSF_ST_PHB_ACT      7
`define MSF_ST_PHC_ACT      8
`define MSF_ST_SUM1         9
`define MSF_ST_PHA_REACT    10
`define MSF_ST_PHB_REACT    11
`define MSF_ST_PHC_REACT    12
`define MSF_ST_SUM2         13
`define MSF_ST_PULSE1       14
`define MSF_ST_PULSE2       15
`define MSF_ST_PULSE3       16
`define MSF_ST_COMPUTE      17
`define MSF_ST_SUM3         18
`define MSF_ST_HARM         19
`define MSF_ST_LO           6
`define MSF_ST_HI           19

// Field positions in the configuration registers
`define MSF_ACC_SRC_BIT     3'd6
`define MSF_CF_DIS_LSB      9
`define MSF_HC_START_BIT    0
`define MSF_HC_STIME_LSB    3
`define MSF_HC_RATE_LSB     5

// Reset values
`define MSF_ACCUMULATION_MODE_REG_RST     8'h00
`define MSF_PULSE_OUTPUT_CONFIG_REG_RST      16'h0000
`define MSF_HARMONIC_CONFIG_REG_RST     8'h00
`define MSF_FLAGS_RST       14'h0000
`define MSF_SIGN_RST        9'h000

// Settling times in milliseconds, and the clock rate
`define MSF_CLK_HZ          100000000
`define MSF_SETTLE0_MS      100
`define MSF_SETTLE1_MS      250
`define MSF_SETTLE2_MS      500
`define MSF_SETTLE3_MS      1000

`endif

// ==== msf_status.sv ====
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "msf_regs.svh"

//
// Overview of operation
// - Flag bit 6 when selected phase A active power sign flips; sign in bit 0.
// - Flag bit 7 when selected phase B active power sign flips; sign in bit 1.
// - Flag bit 8 when selected phase C active power sign flips; sign in bit 2.
// - Flag bit 9 when first pulse path power sum flips sign; sign in bit 3.
// - Flag bit 10 when phase A fundamental reactive power flips; sign in bit 4.
// - Flag bit 11 when phase B fundamental reactive power flips; sign in bit 5.
// - Flag bit 12 when phase C fundamental reactive power flips; sign in bit 6.
// - Flag bit 13 when second pulse path power sum flips sign; sign in bit 7.
// - Flag bit 14 on each falling edge of first pulse output, even disabled.
// - Flag bit 15 on each falling edge of second pulse output, even disabled.
// - Flag bit 16 on each falling edge of third pulse output, even disabled.
// - Flag bit 17 whenever the 8 kHz periodic computation set completes.
// - Flag bit 18 when third pulse path power sum flips sign; sign in bit 8.
// - Flag bit 19 each time harmonic output registers are updated.
// - With start mode 0, harmonic flag waits the selected settling time after setup.
// - With start mode 1, harmonic flag starts immediately after harmonic setup.
// - Reserved upper bits of the status register always read zero.
// - These flags live in the first status register at index 0xE502.
module msf_status #(
  parameter int unsigned SETTLE_CYC_0 = `MSF_SETTLE0_MS * (`MSF_CLK_HZ / 1000),
  parameter int unsigned SETTLE_CYC_1 = `MSF_SETTLE1_MS * (`MSF_CLK_HZ / 1000),
  parameter int unsigned SETTLE_CYC_2 = `MSF_SETTLE2_MS * (`MSF_CLK_HZ / 1000),
  parameter int unsigned SETTLE_CYC_3 = `MSF_SETTLE3_MS * (`MSF_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [17:0]   wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Signs from the metering datapath, 1 = negative
  input  wire logic [2:0]    total_active_sign_i,
  input  wire logic [2:0]    fund_active_sign_i,
  input  wire logic [2:0]    fund_reactive_sign_i,
  input  wire logic [2:0]    pulse_sum_sign_i,
  input  wire logic          periodic_compute_done_i,
  // Raw energy pulses before the disable gate, active low
  input  wire logic          energy_pulse_out_first_i,
  input  wire logic          energy_pulse_out_second_i,
  input  wire logic          energy_pulse_out_third_i,
  // Harmonic block events
  input  wire logic          harmonic_setup_i,
  input  wire logic          harmonic_update_i,
  // Lower flags of the status register, kept elsewhere
  input  wire logic [5:0]    status_low_i,
  // Energy pulse pins after the disable gate
  output logic               energy_pulse_out_first_o,
  output logic               energy_pulse_out_second_o,
  output logic               energy_pulse_out_third_o,
  // Configuration towards the datapath
  output logic [2:0]         pulse_out_first_source_o,
  output logic [2:0]         pulse_out_second_source_o,
  output logic [2:0]         pulse_out_third_source_o,
  output logic [2:0]         harmonic_update_rate_o,
  output logic               active_sign_source_select_o
);

  msf_bus_if bus ();

  // Software-visible state
  logic [7:0]  accumulation_mode_reg;
  logic [15:0] pulse_output_config_reg;
  logic [7:0]  harmonic_config_reg;
  logic [8:0]  power_sign_reg;
  logic [13:0] flags;

  logic [7:0]  next_accumulation_mode_reg;
  logic [15:0] next_pulse_output_config_reg;
  logic [7:0]  next_harmonic_config_reg;
  logic [8:0]  next_power_sign_reg;
  logic [13:0] next_flags;

  // Event tracking
  logic [2:0]  pulse_prev;
  logic [2:0]  next_pulse_prev;
  logic [2:0]  pin_out;
  logic [2:0]  next_pin_out;
  logic        sign_seen;
  logic        next_sign_seen;

  logic [8:0]  sign_now;
  logic [8:0]  sign_flip;
  logic [2:0]  pulse_fall;
  logic        harm_event;
  logic        active_sign_source_select;
  logic [13:0] set_mask;
  logic [13:0] clr_mask;
  logic [31:0] wmask;

  function automatic logic [31:0] byte_mask(input logic [3:0] be);
    byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : byte_mask

  function automatic logic hit(input logic [15:0] idx, input logic [15:0] reg_idx);
    hit = (idx == reg_idx);
  endfunction : hit

  msf_wb_port u_wb_port (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .bus      (bus.port)
  );

  msf_harm_gate #(
    .SETTLE_CYC_0 (SETTLE_CYC_0),
    .SETTLE_CYC_1 (SETTLE_CYC_1),
    .SETTLE_CYC_2 (SETTLE_CYC_2),
    .SETTLE_CYC_3 (SETTLE_CYC_3)
  ) u_harm_gate (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .setup_i     (harmonic_setup_i),
    .update_i    (harmonic_update_i),
    .start_now_i (harmonic_config_reg[`MSF_HC_START_BIT]),
    .stime_i     (harmonic_config_reg[`MSF_HC_STIME_LSB +: 2]),
    .flag_o      (harm_event)
  );

  assign active_sign_source_select = accumulation_mode_reg[`MSF_ACC_SRC_BIT];
  assign wmask                     = byte_mask(bus.be);

  // Configuration registers
  always_comb begin
    next_accumulation_mode_reg   = accumulation_mode_reg;
    next_pulse_output_config_reg = pulse_output_config_reg;
    next_harmonic_config_reg     = harmonic_config_reg;
    if (bus.wr && hit(bus.idx, `MSF_ACCUMULATION_MODE_REG_IDX) && bus.be[0]) begin
      next_accumulation_mode_reg = bus.wdata[7:0];
    end
    if (bus.wr && hit(bus.idx, `MSF_PULSE_OUTPUT_CONFIG_REG_IDX)) begin
      next_pulse_output_config_reg = (pulse_output_config_reg & ~wmask[15:0])
                                     | (bus.wdata[15:0] & wmask[15:0]);
    end
    if (bus.wr && hit(bus.idx, `MSF_HARMONIC_CONFIG_REG_IDX) && bus.be[0]) begin
      next_harmonic_config_reg = bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accumulation_mode_reg   <= `MSF_ACCUMULATION_MODE_REG_RST;
      pulse_output_config_reg <= `MSF_PULSE_OUTPUT_CONFIG_REG_RST;
      harmonic_config_reg     <= `MSF_HARMONIC_CONFIG_REG_RST;
    end else begin
      accumulation_mode_reg   <= next_accumulation_mode_reg;
      pulse_output_config_reg <= next_pulse_output_config_reg;
      harmonic_config_reg     <= next_harmonic_config_reg;
    end
  end

  // Current signs in sign register order
  always_comb begin
    sign_now[0] = active_sign_source_select ? fund_active_sign_i[0] : total_active_sign_i[0];
    sign_now[1] = active_sign_source_select ? fund_active_sign_i[1] : total_active_sign_i[1];
    sign_now[2] = active_sign_source_select ? fund_active_sign_i[2] : total_active_sign_i[2];
    sign_now[3] = pulse_sum_sign_i[0];
    sign_now[4] = fund_reactive_sign_i[0];
    sign_now[5] = fund_reactive_sign_i[1];
    sign_now[6] = fund_reactive_sign_i[2];
    sign_now[7] = pulse_sum_sign_i[1];
    sign_now[8] = pulse_sum_sign_i[2];
  end

  // Signs are sampled once per computation cycle; the first sample only
  // primes the register so that a reset value of positive raises no flag
  always_comb begin
    next_power_sign_reg = power_sign_reg;
    next_sign_seen      = sign_seen;
    sign_flip           = 9'h000;
    if (periodic_compute_done_i) begin
      next_power_sign_reg = sign_now;
      next_sign_seen      = 1'b1;
      if (sign_seen) begin
        sign_flip = sign_now ^ power_sign_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_sign_reg <= `MSF_SIGN_RST;
      sign_seen      <= 1'b0;
    end else begin
      power_sign_reg <= next_power_sign_reg;
      sign_seen      <= next_sign_seen;
    end
  end

  // Pulse edges are taken before the disable gate so disabled pins still flag
  always_comb begin
    next_pulse_prev = {energy_pulse_out_third_i, energy_pulse_out_second_i, energy_pulse_out_first_i};
    pulse_fall      = pulse_prev & ~next_pulse_prev;
    next_pin_out[0] = energy_pulse_out_first_i
                      | pulse_output_config_reg[`MSF_CF_DIS_LSB];
    next_pin_out[1] = energy_pulse_out_second_i
                      | pulse_output_config_reg[`MSF_CF_DIS_LSB + 1];
    next_pin_out[2] = energy_pulse_out_third_i
                      | pulse_output_config_reg[`MSF_CF_DIS_LSB + 2];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_prev <= 3'h7;
      pin_out    <= 3'h7;
    end else begin
      pulse_prev <= next_pulse_prev;
      pin_out    <= next_pin_out;
    end
  end

  // Sticky flags: write one to clear, a new event in the same cycle wins
  always_comb begin
    set_mask = 14'h0000;
    set_mask[`MSF_ST_PHA_ACT   - `MSF_ST_LO] = sign_flip[0];
    set_mask[`MSF_ST_PHB_ACT   - `MSF_ST_LO] = sign_flip[1];
    set_mask[`MSF_ST_PHC_ACT   - `MSF_ST_LO] = sign_flip[2];
    set_mask[`MSF_ST_SUM1      - `MSF_ST_LO] = sign_flip[3];
    set_mask[`MSF_ST_PHA_REACT - `MSF_ST_LO] = sign_flip[4];
    set_mask[`MSF_ST_PHB_REACT - `MSF_ST_LO] = sign_flip[5];
    set_mask[`MSF_ST_PHC_REACT - `MSF_ST_LO] = sign_flip[6];
    set_mask[`MSF_ST_SUM2      - `MSF_ST_LO] = sign_flip[7];
    set_mask[`MSF_ST_PULSE1    - `MSF_ST_LO] = pulse_fall[0];
    set_mask[`MSF_ST_PULSE2    - `MSF_ST_LO] = pulse_fall[1];
    set_mask[`MSF_ST_PULSE3    - `MSF_ST_LO] = pulse_fall[2];
    set_mask[`MSF_ST_COMPUTE   - `MSF_ST_LO] = periodic_compute_done_i;
    set_mask[`MSF_ST_SUM3      - `MSF_ST_LO] = sign_flip[8];
    set_mask[`MSF_ST_HARM      - `MSF_ST_LO] = harm_event;
    clr_mask = 14'h0000;
    if (bus.wr && hit(bus.idx, `MSF_METERING_EVENT_STATUS_0_IDX)) begin
      clr_mask = bus.wdata[`MSF_ST_HI:`MSF_ST_LO] & wmask[`MSF_ST_HI:`MSF_ST_LO];
    end
    next_flags = (flags & ~clr_mask) | set_mask;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= `MSF_FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // Read multiplexer; unmapped indices read as zero
  always_comb begin
    bus.rdata = 32'h0000_0000;
    unique case (bus.idx)
      `MSF_METERING_EVENT_STATUS_0_IDX: begin
        bus.rdata[5:0]                     = status_low_i;
        bus.rdata[`MSF_ST_HI:`MSF_ST_LO]   = flags;
      end
      `MSF_ACCUMULATION_MODE_REG_IDX: bus.rdata[7:0]     = accumulation_mode_reg;
      `MSF_PULSE_OUTPUT_CONFIG_REG_IDX:  bus.rdata[15:0]    = pulse_output_config_reg;
      `MSF_HARMONIC_CONFIG_REG_IDX: bus.rdata[7:0]     = harmonic_config_reg;
      `MSF_POWER_SIGN_REG_IDX:  bus.rdata[8:0]     = power_sign_reg;
      default:          bus.rdata          = 32'h0000_0000;
    endcase
  end

  // Outputs straight from registers
  assign energy_pulse_out_first_o    = pin_out[0];
  assign energy_pulse_out_second_o   = pin_out[1];
  assign energy_pulse_out_third_o    = pin_out[2];
  assign pulse_out_first_source_o    = pulse_output_config_reg[2:0];
  assign pulse_out_second_source_o   = pulse_output_config_reg[5:3];
  assign pulse_out_third_source_o    = pulse_output_config_reg[8:6];
  assign harmonic_update_rate_o      = harmonic_config_reg[`MSF_HC_RATE_LSB +: 3];
  assign active_sign_source_select_o = accumulation_mode_reg[`MSF_ACC_SRC_BIT];

endmodule : msf_status

// ==== msf_status_monitor.sv ====
`timescale 1ns/10ps
`include "msf_regs.svh"
module msf_status_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Datapath side
  input wire logic [5:0]  status_low_i,
  input wire logic        energy_pulse_out_first_i,
  input wire logic        energy_pulse_out_first_o,
  input wire logic [2:0]  pulse_out_first_source_o,
  input wire logic [2:0]  harmonic_update_rate_o,
  input wire logic        active_sign_source_select_o
);
  logic req;
  logic st_rd;
  logic wr0;
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign st_rd = wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i[17:2] == `MSF_METERING_EVENT_STATUS_0_IDX;
  assign wr0   = req && wb_we_i && wb_sel_i[0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_reserved_zero: assert property (st_rd |-> wb_dat_o[31:20] == 12'h000)
    else $error("reserved status bits not zero");
  a_low_passthru: assert property (st_rd |-> wb_dat_o[5:0] == $past(status_low_i))
    else $error("lower status bits differ from their source");
  a_pin_idle_high: assert property ($past(energy_pulse_out_first_i) |-> energy_pulse_out_first_o)
    else $error("pulse pin low without a raw pulse");
  a_src_first: assert property (wr0 && wb_adr_i[17:2] == `MSF_PULSE_OUTPUT_CONFIG_REG_IDX
    |-> ##2 pulse_out_first_source_o == $past(wb_dat_i[2:0], 2)) else $error("first pulse source not written");
  a_rate_field: assert property (wr0 && wb_adr_i[17:2] == `MSF_HARMONIC_CONFIG_REG_IDX
    |-> ##2 harmonic_update_rate_o == $past(wb_dat_i[7:5], 2)) else $error("harmonic rate not written");
  a_source_sel: assert property (wr0 && wb_adr_i[17:2] == `MSF_ACCUMULATION_MODE_REG_IDX
    |-> ##2 active_sign_source_select_o == $past(wb_dat_i[6], 2)) else $error("sign source select not written");
  c_status_read: cover property (st_rd);
  c_pin_low: cover property (!energy_pulse_out_first_o);
  c_harmonic_config_reg_write: cover property (wr0 && wb_adr_i[17:2] == `MSF_HARMONIC_CONFIG_REG_IDX);
endmodule : msf_status_monitor

bind msf_status msf_status_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .status_low_i(status_low_i), .energy_pulse_out_first_i(energy_pulse_out_first_i),
  .energy_pulse_out_first_o(energy_pulse_out_first_o), .pulse_out_first_source_o(pulse_out_first_source_o),
  .harmonic_update_rate_o(harmonic_update_rate_o), .active_sign_source_select_o(active_sign_source_select_o));

// ==== msf_status_tb.sv ====
`timescale 1ns/10ps
`include "msf_regs.svh"
module msf_status_tb;
  localparam logic [31:0] BASE    = 32'h0000_002A;
  localparam logic [31:0] CLR     = 32'h000F_FFC0;
  localparam int          FPOS[9] = '{6, 7, 8, 10, 11, 12, 9, 13, 18};
  localparam int          SPOS[9] = '{0, 1, 2, 4, 5, 6, 3, 7, 8};
  logic        clk_i;
  logic        rst_i;
  logic        req;
  logic        we;
  logic [17:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic [31:0] psx;
  logic        ack;
  logic [2:0]  tot;
  logic [8:0]  sg;
  logic [2:0]  ev;
  logic [2:0]  raw_n;
  logic [2:0]  pin;
  logic [15:0] outs;
  int          n_fail;
  int          tests_run;
  int          cyc_cnt;

  msf_status #(.SETTLE_CYC_0(4), .SETTLE_CYC_1(8), .SETTLE_CYC_2(16), .SETTLE_CYC_3(32)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .total_active_sign_i(tot),
    .fund_active_sign_i(sg[2:0]), .fund_reactive_sign_i(sg[5:3]), .pulse_sum_sign_i(sg[8:6]),
    .periodic_compute_done_i(ev[0]), .energy_pulse_out_first_i(raw_n[0]), .energy_pulse_out_second_i(raw_n[1]),
    .energy_pulse_out_third_i(raw_n[2]), .harmonic_setup_i(ev[1]), .harmonic_update_i(ev[2]),
    .status_low_i(BASE[5:0]), .energy_pulse_out_first_o(pin[0]), .energy_pulse_out_second_o(pin[1]),
    .energy_pulse_out_third_o(pin[2]), .pulse_out_first_source_o(outs[3:1]),
    .pulse_out_second_source_o(outs[9:7]), .pulse_out_third_source_o(outs[12:10]),
    .harmonic_update_rate_o(outs[6:4]), .active_sign_source_select_o(outs[0]));
  assign outs[15:13] = pin;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Classic single cycle; waits for ack under a bound rather than assuming the latency
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) n_fail++;
    rd = rdat;
    req <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string msg);
    xfer(1'b0, idx, 32'h0000_0000);
    check(rd, exp, msg);
  endtask : rd_chk

  task automatic ev_pulse(input logic [2:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 3'b000;
  endtask : ev_pulse

  // Pins are sampled one edge after the raw low level, where the registered copy shows it
  task automatic cf_pulse(input logic [2:0] m, input logic [2:0] exp_pin);
    @(posedge clk_i);
    raw_n <= ~m;
    @(posedge clk_i);
    raw_n <= 3'b111;
    #1;
    check({29'h0000_0000, pin}, {29'h0000_0000, exp_pin}, "pulse pins");
  endtask : cf_pulse

  function automatic logic [31:0] fl(input int b);
    return BASE | (32'h0000_0001 << b);
  endfunction : fl

  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  initial begin
    {rst_i, req, we, adr, wdat, tot, sg, ev, raw_n} = {1'b1, 67'h0, 3'b111};
    {n_fail, tests_run, cyc_cnt, psx} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, BASE, "status after reset");
    rd_chk(`MSF_ACCUMULATION_MODE_REG_IDX, 32'h0000_0000, "accum mode after reset");
    rd_chk(`MSF_PULSE_OUTPUT_CONFIG_REG_IDX, 32'h0000_0000, "pulse config after reset");
    rd_chk(`MSF_HARMONIC_CONFIG_REG_IDX, 32'h0000_0000, "harmonic config after reset");
    rd_chk(`MSF_POWER_SIGN_REG_IDX, 32'h0000_0000, "sign reg after reset");
    check({16'h0000, outs}, 32'h0000_E000, "outputs after reset");
    $display("test reset done");
    xfer(1'b1, `MSF_ACCUMULATION_MODE_REG_IDX, 32'h0000_0040);
    xfer(1'b1, `MSF_PULSE_OUTPUT_CONFIG_REG_IDX, 32'h0000_0FFF);
    xfer(1'b1, `MSF_HARMONIC_CONFIG_REG_IDX, 32'h0000_00FF);
    xfer(1'b1, `MSF_POWER_SIGN_REG_IDX, 32'hFFFF_FFFF);
    xfer(1'b1, 16'h0001, 32'hFFFF_FFFF);
    rd_chk(`MSF_ACCUMULATION_MODE_REG_IDX, 32'h0000_0040, "accum mode");
    rd_chk(`MSF_PULSE_OUTPUT_CONFIG_REG_IDX, 32'h0000_0FFF, "pulse config");
    rd_chk(`MSF_HARMONIC_CONFIG_REG_IDX, 32'h0000_00FF, "harmonic config");
    rd_chk(`MSF_POWER_SIGN_REG_IDX, 32'h0000_0000, "sign reg read only");
    rd_chk(16'h0001, 32'h0000_0000, "unmapped read");
    check({16'h0000, outs}, 32'h0000_FFFF, "config outputs");
    $display("test config done");
    ev_pulse(3'b001);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_COMPUTE), "compute flag");
    xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
    @(posedge clk_i);
    tot <= 3'b111;
    ev_pulse(3'b001);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_COMPUTE), "unselected total sign");
    xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      sg[i] <= 1'b1;
      psx = psx | (32'h0000_0001 << SPOS[i]);
      ev_pulse(3'b001);
      rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(FPOS[i]) | fl(`MSF_ST_COMPUTE), "sign flag");
      rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(FPOS[i]) | fl(`MSF_ST_COMPUTE), "sign flag held");
      rd_chk(`MSF_POWER_SIGN_REG_IDX, psx, "sign register");
      xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
      rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, BASE, "flags cleared");
    end
    // Total power selected: phase A total sign turns positive
    xfer(1'b1, `MSF_ACCUMULATION_MODE_REG_IDX, 32'h0000_0000);
    @(posedge clk_i);
    tot <= 3'b110;
    ev_pulse(3'b001);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_PHA_ACT) | fl(`MSF_ST_COMPUTE), "total sign flag");
    rd_chk(`MSF_POWER_SIGN_REG_IDX, 32'h0000_01FE, "total sign register");
    xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
    $display("test signs done");
    for (int k = 0; k < 3; k++) begin
      cf_pulse(3'b001 << k, 3'b111);
      rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_PULSE1 + k), "pulse flag while disabled");
      xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
    end
    xfer(1'b1, `MSF_PULSE_OUTPUT_CONFIG_REG_IDX, 32'h0000_0000);
    cf_pulse(3'b001, 3'b110);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_PULSE1), "pulse flag enabled");
    xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
    $display("test pulses done");
    xfer(1'b1, `MSF_HARMONIC_CONFIG_REG_IDX, 32'h0000_0008);
    ev_pulse(3'b100);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, BASE, "update before setup");
    ev_pulse(3'b010);
    ev_pulse(3'b100);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, BASE, "update while settling");
    repeat (12) @(posedge clk_i);
    ev_pulse(3'b100);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_HARM), "update after settling");
    xfer(1'b1, `MSF_METERING_EVENT_STATUS_0_IDX, CLR);
    xfer(1'b1, `MSF_HARMONIC_CONFIG_REG_IDX, 32'h0000_0001);
    ev_pulse(3'b010);
    ev_pulse(3'b100);
    rd_chk(`MSF_METERING_EVENT_STATUS_0_IDX, fl(`MSF_ST_HARM), "immediate start");
    $display("test harmonic done");
    finish_test();
  end
endmodule : msf_status_tb

// ==== msf_wb_port.sv ====
`timescale 1ns/10ps
module msf_wb_port (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [17:0]   wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Register side
  msf_bus_if.port            bus
);

  logic        req;
  logic        next_ack;
  logic [31:0] next_dat;

  // One access per request; ack drops in the cycle after it was given
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus.wr    = req && wb_we_i;
  assign bus.idx   = wb_adr_i[17:2];
  assign bus.be    = wb_sel_i;
  assign bus.wdata = wb_dat_i;

  always_comb begin
    next_ack = req;
    next_dat = wb_dat_o;
    if (req && !wb_we_i) begin
      next_dat = bus.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

endmodule : msf_wb_port
